// ---- verilog/apss_cfg.svh ----
`ifndef APSS_CFG_SVH
`define APSS_CFG_SVH
// ----------------------------------------
// Port offsets from the audio base
// ----------------------------------------
`define APSS_OFS_MIX_INDEX      4'h4
`define APSS_OFS_MIX_DATA       4'h5
`define APSS_OFS_ACTIVITY       4'h6
`define APSS_OFS_POWER_CTRL     4'h7
// ----------------------------------------
// Activity port fields
// ----------------------------------------
`define APSS_ACT_RESET_BIT      0
`define APSS_ACT_MIDI_BIT       2
`define APSS_ACT_POWERED_BIT    3
`define APSS_ACT_SERIAL_BIT     4
`define APSS_ACT_AUDIO_BIT      5
`define APSS_ACT_MIXER_BIT      6
`define APSS_ACT_SYSTEM_BIT     7
// ----------------------------------------
// Power control fields and reset values
// ----------------------------------------
`define APSS_PC_REQ_BIT         2
`define APSS_PC_PARTIAL_BIT     3
`define APSS_PC_SUSPEND_BIT     7
`define APSS_PC_RESET_VAL       8'h00
`define APSS_HOLD_RESET_VAL     1'b1
// ----------------------------------------
// Timing
// ----------------------------------------
`define APSS_CLK_MHZ            100
`define APSS_AOUT_MIN_MS        48
`define APSS_AOUT_MAX_MS        64
`define APSS_CTX_BYTES          782
`endif

// ---- verilog/apss_pkg.sv ----
package apss_pkg;
	typedef enum logic [1:0] {
		APSS_FULL_DOWN    = 2'b00,
		APSS_PARTIAL_DOWN = 2'b01,
		APSS_FULL_UP      = 2'b10
	} apss_state_e;

	typedef struct packed {
		logic       valid;
		logic       write;
		logic [3:0] offset;
		logic [7:0] wdata;
	} apss_io_s;

	typedef struct packed {
		logic audio_en;
		logic fm_en;
		logic osc_en;
		logic analog_en;
		logic line_out_en;
	} apss_pwr_s;
endpackage

// ---- verilog/apss_sequencer.sv ----
// Function
// - Three power states 0,1,2; hardware reset enters full power-up.
// - After full power-down wake other than by hardware reset, line outputs stay off 48 to 64 ms.
// - Low on volume up, down or mute pin wakes the device.
// - Partial power-down keeps analog, mixer, oscillator; audio and FM off.
// - Partial down wakes on audio or FM access except offsets 4h-7h.
// - Bit 3 clear plus rising bit 2 requests full power-down.
// - Activity bit 3 reads 0 while powered down.
// - Activity bit 0 is reset hold; host clears it, waits 1 ms.
// - Activity bit 2 shows MIDI mode; serial MIDI input never wakes.
// - Activity bits 7..5 are latched system, mixer, audio flags; bit 4 is live serial.
// - Hardware or software reset wakes from full down, context lost.
// - Full power-down wakes on any access except offsets 6h and 7h.
// - DMA accesses also wake the device.
// - Auto wake from full down only with external stable clock.
// - Full power-down stops oscillator and powers down analog.
// - DMA and interrupt request outputs freeze on entering power-down.
// - Bit 7 pulse interrupts microcontroller to upload context.
// - Saved context occupies 782 bytes.
`timescale 1ns/1ps
`default_nettype none
`include "apss_cfg.svh"
module apss_sequencer (
	input  wire logic                  clk,
	input  wire logic                  rst_n,
	input  wire apss_pkg::apss_io_s    io,
	output logic [7:0]                 io_rdata,
	input  wire logic                  dma_ack,
	input  wire logic                  sys_activity,
	input  wire logic                  serial_activity,
	input  wire logic                  midi_mode,
	input  wire logic                  soft_reset,
	input  wire logic                  ext_clock_mode,
	input  wire logic                  hw_volume_up_pin,
	input  wire logic                  hw_volume_down_pin,
	input  wire logic                  hw_mute_pin,
	input  wire logic                  dma_req_core,
	input  wire logic                  irq_core,
	output logic                       dma_req,
	output logic                       irq,
	output logic [1:0]                 power_state,
	output apss_pkg::apss_pwr_s        pwr,
	output logic                       uc_powerdown_irq,
	output logic                       uc_suspend_irq,
	output logic                       context_lost,
	output logic [9:0]                 context_bytes
);
	import apss_pkg::*;

	localparam int unsigned AOUT_MIN_CYC = `APSS_AOUT_MIN_MS * `APSS_CLK_MHZ * 1000;
	localparam int unsigned AOUT_MAX_CYC = `APSS_AOUT_MAX_MS * `APSS_CLK_MHZ * 1000;
	// Aim below the top of the window so the enable lands inside it
	parameter int unsigned AOUT_DELAY_CYC = (AOUT_MIN_CYC + AOUT_MAX_CYC) / 2;

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	// Pins idle high, so the flops reset high and no false wake follows reset
	logic [2:0] vol_meta;
	logic [2:0] vol_sync;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			vol_meta <= 3'h7;
			vol_sync <= 3'h7;
		end else begin
			vol_meta <= {hw_mute_pin, hw_volume_down_pin, hw_volume_up_pin};
			vol_sync <= vol_meta;
		end
	end

	// ----------------------------------------
	// Access decode
	// ----------------------------------------
	function automatic logic is_ofs(input logic [3:0] ofs, input logic [3:0] ref_ofs);
		return ofs == ref_ofs;
	endfunction

	function automatic logic is_full_up(input apss_state_e s);
		return s == APSS_FULL_UP;
	endfunction

	logic acc_act;
	logic acc_pc;
	logic acc_mix;
	logic acc_other;
	logic pc_wr;

	assign acc_act   = io.valid && is_ofs(io.offset, `APSS_OFS_ACTIVITY);
	assign acc_pc    = io.valid && is_ofs(io.offset, `APSS_OFS_POWER_CTRL);
	assign acc_mix   = io.valid && (is_ofs(io.offset, `APSS_OFS_MIX_INDEX)
		|| is_ofs(io.offset, `APSS_OFS_MIX_DATA));
	// The activity and control ports never count as activity of their own
	assign acc_other = io.valid && !acc_act && !acc_pc && !acc_mix;
	assign pc_wr     = acc_pc && io.write;

	// ----------------------------------------
	// Power control register and edges
	// ----------------------------------------
	logic [7:0] power_control;
	logic       req_rise;
	logic       susp_rise;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			power_control <= `APSS_PC_RESET_VAL;
		end else if (soft_reset) begin
			// Request bits drop too, so the next pulse is a fresh edge
			power_control <= `APSS_PC_RESET_VAL;
		end else if (pc_wr) begin
			power_control <= io.wdata;
		end
	end

	// Compare written value with held one: one request per high pulse
	assign req_rise  = pc_wr && io.wdata[`APSS_PC_REQ_BIT]
		&& !power_control[`APSS_PC_REQ_BIT];
	assign susp_rise = pc_wr && io.wdata[`APSS_PC_SUSPEND_BIT]
		&& !power_control[`APSS_PC_SUSPEND_BIT];

	// ----------------------------------------
	// Power state machine
	// ----------------------------------------
	apss_state_e state;
	apss_state_e next_state;
	logic        wake_vol;
	logic        wake_partial;
	logic        wake_full;

	assign wake_vol     = vol_sync != 3'h7;
	// Serial MIDI input is not a wake source; data in that mode is lost
	assign wake_partial = wake_vol || dma_ack || acc_other;
	// Without an external clock the oscillator is dead here
	assign wake_full    = ext_clock_mode && (wake_partial || (io.valid && !acc_act
		&& !acc_pc));
	// With a crystal the host must first write bit 3 and wait out the
	// oscillator start; that write alone moves the state to partial

	always_comb begin
		next_state = state;
		case (state)
			APSS_FULL_UP: begin
				if (req_rise) begin
					next_state = io.wdata[`APSS_PC_PARTIAL_BIT] ? APSS_PARTIAL_DOWN
						: APSS_FULL_DOWN;
				end
			end
			APSS_PARTIAL_DOWN: begin
				if (req_rise && !io.wdata[`APSS_PC_PARTIAL_BIT]) begin
					next_state = APSS_FULL_DOWN;
				end else if (wake_partial) begin
					next_state = APSS_FULL_UP;
				end
			end
			APSS_FULL_DOWN: begin
				if (wake_full) begin
					next_state = APSS_FULL_UP;
				end else if (pc_wr && io.wdata[`APSS_PC_PARTIAL_BIT]) begin
					next_state = APSS_PARTIAL_DOWN;
				end
			end
			default: next_state = APSS_FULL_UP;
		endcase
		if (soft_reset) begin
			next_state = APSS_FULL_UP;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= APSS_FULL_UP;
		end else if (soft_reset) begin
			// Soft reset restarts in full power-up; context is not restored
			state <= APSS_FULL_UP;
		end else begin
			state <= next_state;
		end
	end

	assign power_state = state;

	// ----------------------------------------
	// Line output enable delay
	// ----------------------------------------
	// Wide enough for the whole 64 ms window at 100 MHz
	logic [22:0] aout_cnt;
	logic        aout_ok;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			aout_cnt <= '0;
			aout_ok  <= 1'b1;
		end else if (state == APSS_FULL_DOWN) begin
			aout_cnt <= '0;
			aout_ok  <= 1'b0;
		end else if (!aout_ok && is_full_up(state)) begin
			if (aout_cnt == 23'(AOUT_DELAY_CYC - 1)) begin
				aout_ok <= 1'b1;
			end
			aout_cnt <= aout_cnt + 23'h1;
		end else if (!aout_ok) begin
			aout_cnt <= '0;
		end
	end

	// ----------------------------------------
	// Domain enables
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pwr <= '{audio_en: 1'b1, fm_en: 1'b1, osc_en: 1'b1, analog_en: 1'b1,
				line_out_en: 1'b1};
		end else begin
			// Follow next_state so the domains switch with the state; line_out_en follows state, one cycle after it
			pwr.audio_en    <= is_full_up(next_state);
			pwr.fm_en       <= is_full_up(next_state);
			pwr.osc_en      <= next_state != APSS_FULL_DOWN;
			pwr.analog_en   <= next_state != APSS_FULL_DOWN;
			pwr.line_out_en <= aout_ok && is_full_up(state);
		end
	end

	// ----------------------------------------
	// Frozen request outputs
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dma_req <= 1'b0;
			irq     <= 1'b0;
		end else if (is_full_up(next_state)) begin
			// The core may be clock-gated outside full power-up, so its request
			// lines are not trusted; the pins keep the last value it drove
			dma_req <= dma_req_core;
			irq     <= irq_core;
		end
	end

	// ----------------------------------------
	// Microcontroller events and context
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			uc_powerdown_irq <= 1'b0;
			uc_suspend_irq   <= 1'b0;
			context_lost     <= 1'b1;
		end else begin
			uc_powerdown_irq <= req_rise;
			uc_suspend_irq   <= susp_rise;
			// A soft reset wins over a same-cycle suspend for context_lost, but uc_suspend_irq still pulses
			if (soft_reset) begin
				context_lost <= 1'b1;
			end else if (susp_rise) begin
				context_lost <= 1'b0;
			end
		end
	end

	assign context_bytes = 10'(`APSS_CTX_BYTES);

	// ----------------------------------------
	// Activity port
	// ----------------------------------------
	logic       hold_reset;
	logic [2:0] act_latch;
	logic       act_rd;

	assign act_rd = acc_act && !io.write;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			hold_reset <= `APSS_HOLD_RESET_VAL;
		end else if (acc_act && io.write && !io.wdata[`APSS_ACT_RESET_BIT]) begin
			hold_reset <= 1'b0;
		end
	end

	// Read clears the latches; a same-cycle event still sets
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			act_latch <= 3'h0;
		end else begin
			act_latch[2] <= (act_latch[2] && !act_rd) || sys_activity || dma_ack;
			act_latch[1] <= (act_latch[1] && !act_rd) || acc_mix;
			act_latch[0] <= (act_latch[0] && !act_rd) || acc_other || dma_ack;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			io_rdata <= 8'h00;
		end else if (act_rd) begin
			// Bit 3 is low in partial and full power-down alike
			io_rdata <= {act_latch, serial_activity,
				is_full_up(state), midi_mode, 1'b0, hold_reset};
		end else if (acc_pc && !io.write) begin
			io_rdata <= power_control;
		end else begin
			io_rdata <= 8'h00;
		end
	end
endmodule
`default_nettype wire

// ---- verif/apss_checker_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
module apss_checker (
	input wire logic                clk,
	input wire logic                rst_n,
	input wire apss_pkg::apss_io_s  io,
	input wire logic                dma_ack,
	input wire logic                soft_reset,
	input wire logic                ext_clock_mode,
	input wire logic                dma_req,
	input wire logic                irq,
	input wire logic [1:0]          power_state,
	input wire apss_pkg::apss_pwr_s pwr,
	input wire logic                uc_suspend_irq
);
	import apss_pkg::*;
	logic [7:0] pc_q;
	logic       wr7;
	logic       rise2;
	assign wr7 = io.valid && io.write && io.offset == 4'h7;
	assign rise2 = wr7 && io.wdata[2] && !pc_q[2];
	// Shadow copy so a held bit 2 is not seen as a new edge
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			pc_q <= 8'h00;
		else if (soft_reset)
			pc_q <= 8'h00;
		else if (wr7)
			pc_q <= io.wdata;
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	sequence s_down2;
		power_state != 2'h2 ##1 power_state != 2'h2;
	endsequence
	sequence s_wake_full;
		power_state == 2'h0 ##1 power_state == 2'h2;
	endsequence
	AST_PART_REQ: assert property (
		rise2 && io.wdata[3] && power_state == 2'h2 |=> power_state == 2'h1)
		else $error("partial request ignored");
	AST_FULL_REQ: assert property (
		rise2 && !io.wdata[3] && power_state != 2'h0 |=> power_state == 2'h0)
		else $error("full request ignored");
	AST_SUSP: assert property (
		wr7 && io.wdata[7] && !pc_q[7] |=> uc_suspend_irq ##1 !uc_suspend_irq)
		else $error("suspend pulse wrong");
	AST_PART_WAKE: assert property (
		power_state == 2'h1 && io.valid && io.offset[3:2] != 2'h1 |=> power_state == 2'h2)
		else $error("partial wake missed");
	AST_FULL_WAKE: assert property (
		power_state == 2'h0 && ext_clock_mode
		&& (dma_ack || io.valid && io.offset[3:1] != 3'h3) |=> power_state == 2'h2)
		else $error("full wake missed");
	AST_FREEZE: assert property (
		s_down2 |-> $stable(dma_req) && $stable(irq))
		else $error("requests not frozen");
	AST_LINE_OUT: assert property (
		s_wake_full |-> !pwr.line_out_en [*8])
		else $error("line out enabled early");
	AST_PWR: assert property (
		pwr.audio_en == (power_state == 2'h2) && pwr.osc_en == (power_state != 2'h0))
		else $error("enables wrong");
endmodule
bind apss_sequencer apss_checker apss_checker_i (.clk, .rst_n, .io, .dma_ack, .soft_reset,
	.ext_clock_mode, .dma_req, .irq, .power_state, .pwr, .uc_suspend_irq);
`default_nettype wire

// ---- verif/apss_host.sv ----
`timescale 1ns/1ps
`default_nettype none
module apss_host (
	input  wire logic         clk,
	input  wire logic [7:0]   io_rdata,
	output var apss_pkg::apss_io_s io
);
	import apss_pkg::*;
	initial io = '0;
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		io <= '{1'b1, 1'b1, a, d};
		@(posedge clk);
		io <= '0;
		#1;
	endtask
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk);
		io <= '{1'b1, 1'b0, a, 8'h00};
		@(posedge clk);
		io <= '0;
		#1;
		d = io_rdata;
	endtask
	// Base value b written first and kept, bit 2 pulsed around it
	task automatic pd(input logic [7:0] b);
		wr(4'h7, b);
		wr(4'h7, b | 8'h04);
		wr(4'h7, b);
	endtask
endmodule
`default_nettype wire

// ---- verif/apss_sequencer_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module apss_sequencer_test;
	import apss_pkg::*;
	localparam int DLY = 50;
	logic clk = 0, rst_n = 0, dma_ack = 0, sys_activity = 0, serial_activity = 0;
	logic midi_mode = 0, soft_reset = 0, ext_clock_mode = 0, dma_req_core = 0;
	logic irq_core = 0, hw_volume_up_pin = 1, hw_volume_down_pin = 1, hw_mute_pin = 1;
	logic [7:0] io_rdata;
	logic       dma_req, irq, uc_powerdown_irq, uc_suspend_irq, context_lost;
	logic [1:0] power_state;
	logic [9:0] context_bytes;
	apss_io_s   io;
	apss_pwr_s  pwr;
	int n_fail = 0;
	int checked = 0;
	apss_host apss_host_i (.clk, .io_rdata, .io);
	apss_sequencer #(.AOUT_DELAY_CYC(DLY)) apss_sequencer_i (.clk, .rst_n, .io, .io_rdata,
		.dma_ack, .sys_activity, .serial_activity, .midi_mode, .soft_reset, .ext_clock_mode,
		.hw_volume_up_pin, .hw_volume_down_pin, .hw_mute_pin, .dma_req_core, .irq_core,
		.dma_req, .irq, .power_state, .pwr, .uc_powerdown_irq, .uc_suspend_irq,
		.context_lost, .context_bytes);
	always #5 clk = ~clk;
	task automatic chk(input string s, input logic [9:0] got, input logic [9:0] exp);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("FAIL %s exp %h got %h", s, exp, got);
		end
	endtask
	task automatic test_done;
		if (n_fail == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic t_act;
		logic [7:0] v;
		apss_host_i.rd(4'h6, v);
		chk("act", v, 8'h09);
		apss_host_i.wr(4'h6, 8'h00);
		@(posedge clk);
		sys_activity <= 1'b1;
		midi_mode <= 1'b1;
		serial_activity <= 1'b1;
		@(posedge clk);
		sys_activity <= 1'b0;
		apss_host_i.wr(4'h4, 8'h00);
		apss_host_i.rd(4'h6, v);
		chk("act", v, 8'hDC);
		apss_host_i.rd(4'h6, v);
		chk("act", v, 8'h1C);
		@(posedge clk);
		midi_mode <= 1'b0;
		serial_activity <= 1'b0;
	endtask
	task automatic t_part;
		apss_host_i.wr(4'h7, 8'h08);
		apss_host_i.wr(4'h7, 8'h0C);
		chk("pdirq", uc_powerdown_irq, 1'b1);
		apss_host_i.wr(4'h7, 8'h08);
		chk("pdirq", uc_powerdown_irq, 1'b0);
		chk("state", power_state, 2'h1);
		chk("en", {pwr.audio_en, pwr.fm_en, pwr.analog_en}, 3'h1);
		apss_host_i.wr(4'h5, 8'h00);
		chk("state", power_state, 2'h1);
		apss_host_i.wr(4'h2, 8'h00);
		chk("state", power_state, 2'h2);
	endtask
	task automatic t_full;
		@(posedge clk);
		dma_req_core <= 1'b1;
		irq_core <= 1'b1;
		apss_host_i.pd(8'h00);
		@(posedge clk);
		dma_req_core <= 1'b0;
		irq_core <= 1'b0;
		repeat (3) @(posedge clk);
		#1 chk("frz", {dma_req, irq}, 2'h3);
		chk("state", power_state, 2'h0);
		chk("osc", {pwr.osc_en, pwr.analog_en}, 2'h0);
		apss_host_i.wr(4'h1, 8'h00);
		chk("state", power_state, 2'h0);
		apss_host_i.wr(4'h7, 8'h08);
		chk("state", power_state, 2'h1);
		apss_host_i.wr(4'h1, 8'h00);
		chk("state", power_state, 2'h2);
	endtask
	task automatic t_wake;
		logic [7:0] v;
		for (int k = 0; k < 6; k++) begin
			@(posedge clk);
			ext_clock_mode <= 1'b1;
			apss_host_i.pd(8'h00);
			apss_host_i.rd(4'h6, v);
			chk("down", {v[3], power_state}, 3'h0);
			if (k == 3) begin
				apss_host_i.wr(4'h7, 8'h80);
				chk("lost", context_lost, 1'b0);
			end
			@(posedge clk);
			dma_ack <= k == 1;
			hw_volume_up_pin <= k != 4;
			hw_volume_down_pin <= k != 2;
			hw_mute_pin <= k != 5;
			soft_reset <= k == 3;
			if (k == 0)
				apss_host_i.wr(4'h3, 8'h00);
			repeat (4) @(posedge clk);
			dma_ack <= 1'b0;
			hw_volume_up_pin <= 1'b1;
			hw_volume_down_pin <= 1'b1;
			hw_mute_pin <= 1'b1;
			soft_reset <= 1'b0;
			#1 chk("wake", power_state, 2'h2);
			repeat (DLY - 10) @(posedge clk);
			#1 chk("aout", pwr.line_out_en, 1'b0);
			repeat (15) @(posedge clk);
			#1 chk("aout", pwr.line_out_en, 1'b1);
			if (k == 3)
				chk("lost", context_lost, 1'b1);
		end
	endtask
	task automatic t_susp;
		apss_host_i.wr(4'h7, 8'h80);
		chk("susp", uc_suspend_irq, 1'b1);
		apss_host_i.wr(4'h7, 8'h80);
		chk("susp", uc_suspend_irq, 1'b0);
		chk("ctx", context_bytes, 10'h30E);
		chk("lost", context_lost, 1'b0);
	endtask
	task automatic t_resume;
		logic [7:0] v;
		apss_host_i.pd(8'h00);
		chk("state", power_state, 2'h0);
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		#1 chk("state", power_state, 2'h2);
		chk("lost", context_lost, 1'b1);
		apss_host_i.wr(4'hC, 8'hC6);
		apss_host_i.wr(4'hC, 8'hC1);
		chk("state", power_state, 2'h2);
		apss_host_i.rd(4'h6, v);
		chk("act", v, 8'h29);
	endtask
	initial begin
		#100us;
		n_fail++;
		test_done;
	end
	initial begin
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		#1 chk("state", power_state, 2'h2);
		t_act;
		t_part;
		t_full;
		t_wake;
		t_susp;
		t_resume;
		test_done;
	end
endmodule
`default_nettype wire
